// ===== mac_pkg.sv
// Constants and types shared by the signed multiply/accumulate unit.
`default_nettype none

package mac_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned FACTOR_WIDTH  = 8;
  localparam int unsigned PRODUCT_WIDTH = 16;
  localparam int unsigned SUM_WIDTH     = 32;
  localparam int unsigned HALF_WIDTH    = 16;
  localparam int unsigned ADDR_WIDTH    = 8;

  // ------------------------------------------------------------------
  // Register bank and offsets
  // ------------------------------------------------------------------
  localparam logic       MAC_BANK                = 1'h0;
  localparam logic [7:0] PRODUCT_FACTOR_X_ADDR   = 8'he8;
  localparam logic [7:0] PRODUCT_FACTOR_Y_ADDR   = 8'he9;
  localparam logic [7:0] PRODUCT_HIGH_BYTE_ADDR  = 8'hea;
  localparam logic [7:0] PRODUCT_LOW_BYTE_ADDR   = 8'heb;
  localparam logic [7:0] SUM_BYTE1_ADDR          = 8'hec;
  localparam logic [7:0] SUM_BYTE0_ADDR          = 8'hed;
  localparam logic [7:0] SUM_BYTE3_ADDR          = 8'hee;
  localparam logic [7:0] SUM_BYTE2_ADDR          = 8'hef;

  // ------------------------------------------------------------------
  // Reset values and the answer to an unmapped read
  // ------------------------------------------------------------------
  localparam logic [7:0]  FACTOR_RESET    = 8'h00;
  localparam logic [15:0] PRODUCT_RESET   = 16'h0000;
  localparam logic [15:0] HALF_RESET      = 16'h0000;
  localparam logic [7:0]  READ_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    op_none,
    op_multiply,
    op_accumulate,
    op_clear
  } operation_t;

  typedef enum logic {
    carry_idle,
    carry_due
  } carry_state_t;

endpackage : mac_pkg

`default_nettype wire

// ===== accum_if.sv
// Interface between the register front end and the split accumulator.
`timescale 1ns/10ps
`default_nettype none

interface accum_if;

  logic                                add_strobe;
  logic signed [mac_pkg::PRODUCT_WIDTH-1:0] addend;
  logic                                clear_strobe;
  logic [mac_pkg::SUM_WIDTH-1:0]       sum;

  modport front (
    output add_strobe,
    output addend,
    output clear_strobe,
    input  sum
  );

  modport accum (
    input  add_strobe,
    input  addend,
    input  clear_strobe,
    output sum
  );

endinterface : accum_if

`default_nettype wire

// ===== signed_multiplier.sv
// Combinational 8x8 two's complement multiplier.
`timescale 1ns/10ps
`default_nettype none

module signed_multiplier (
  input  wire logic [mac_pkg::FACTOR_WIDTH-1:0]  factor_x, // X factor
  input  wire logic [mac_pkg::FACTOR_WIDTH-1:0]  factor_y, // Y factor
  output logic      [mac_pkg::PRODUCT_WIDTH-1:0] product   // Signed product
);

  // Both factors are signed, so -128 * -128 gives 16'h4000 exactly.
  assign product = mac_pkg::PRODUCT_WIDTH'($signed(factor_x)
                                          * $signed(factor_y));

endmodule : signed_multiplier

`default_nettype wire

// ===== split_accumulator.sv
// Thirty-two bit accumulator whose upper half settles one cycle late.
`timescale 1ns/10ps
`default_nettype none

module split_accumulator (
  input  wire logic clock, // Unit clock
  input  wire logic reset, // Asynchronous reset, active high
  accum_if.accum    acc    // Add, clear and sum
);

  logic [mac_pkg::HALF_WIDTH-1:0] low_half;
  logic [mac_pkg::HALF_WIDTH-1:0] high_half;
  logic [mac_pkg::HALF_WIDTH-1:0] high_addend;
  logic [mac_pkg::HALF_WIDTH:0]   next_low;
  mac_pkg::carry_state_t          carry_state;

  // ------------------------------------------------------------------
  // Lower half
  // ------------------------------------------------------------------
  // Splitting the carry chain keeps the adder short; the price is that
  // the upper bytes lag one cycle behind the lower bytes.
  assign next_low = {1'b0, low_half} + {1'b0, acc.addend};

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      low_half <= mac_pkg::HALF_RESET;
    else if (acc.clear_strobe)
      low_half <= mac_pkg::HALF_RESET;
    else if (acc.add_strobe)
      low_half <= next_low[mac_pkg::HALF_WIDTH-1:0];
  end

  // ------------------------------------------------------------------
  // Deferred upper half
  // ------------------------------------------------------------------
  // The sign extension of the product plus the carry out of the lower
  // half is parked here and added on the following edge.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      high_addend <= mac_pkg::HALF_RESET;
    else if (acc.add_strobe)
      high_addend <= {mac_pkg::HALF_WIDTH{acc.addend[mac_pkg::HALF_WIDTH-1]}}
                     + {{(mac_pkg::HALF_WIDTH-1){1'b0}},
                        next_low[mac_pkg::HALF_WIDTH]};
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      carry_state <= mac_pkg::carry_idle;
    else if (acc.clear_strobe)
      carry_state <= mac_pkg::carry_idle;
    else if (acc.add_strobe)
      carry_state <= mac_pkg::carry_due;
    else
      carry_state <= mac_pkg::carry_idle;
  end

  // Wraps modulo two to the thirty-second with no overflow flag.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      high_half <= mac_pkg::HALF_RESET;
    else if (acc.clear_strobe)
      high_half <= mac_pkg::HALF_RESET;
    else
    begin
      case (carry_state)
        mac_pkg::carry_due:
          high_half <= high_half + high_addend;
        default:
          high_half <= high_half;
      endcase
    end
  end

  assign acc.sum = {high_half, low_half};

endmodule : split_accumulator

`default_nettype wire

// ===== signed_multiply_accumulate.sv
// Register-mapped signed multiplier and multiply/accumulate unit.
`timescale 1ns/10ps
`default_nettype none

module signed_multiply_accumulate (
  input  wire logic       clock,          // Unit clock, 25 MHz
  input  wire logic       reset,          // Asynchronous reset, active high
  input  wire logic       bus_bank,       // Register bank select
  input  wire logic [7:0] bus_address,    // Register address
  input  wire logic       bus_write,      // Write strobe, one cycle
  input  wire logic       bus_read,       // Read strobe, one cycle
  input  wire logic [7:0] bus_write_data, // Data written by the CPU
  output logic      [7:0] bus_read_data,  // Data returned to the CPU
  output logic      [1:0] last_operation, // Most recent operation kind
  output logic            sum_settling    // Upper sum bytes not yet valid
);

  // ------------------------------------------------------------------
  // Operand and result state
  // ------------------------------------------------------------------
  logic [7:0]  factor_x;
  logic [7:0]  factor_y;
  logic [7:0]  next_x;
  logic [7:0]  next_y;
  logic [15:0] product;
  logic [15:0] next_product;
  logic [7:0]  next_read_data;

  mac_pkg::operation_t operation;
  mac_pkg::operation_t next_operation;

  accum_if acc ();

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  logic in_bank;
  logic write_product_factor_x;
  logic write_product_factor_y;
  logic write_acc_x;
  logic write_acc_y;
  logic write_clear;
  logic any_x_write;
  logic any_y_write;
  logic hit_factor_x;
  logic hit_factor_y;
  logic hit_product_high;
  logic hit_product_low;
  logic hit_sum_byte1;
  logic hit_sum_byte0;
  logic hit_sum_byte3;
  logic hit_sum_byte2;

  assign in_bank = (bus_bank == mac_pkg::MAC_BANK);

  // One match per register, shared by the write and the read decoders
  // so that the two maps cannot drift apart.
  always_comb
  begin
    hit_factor_x     = 1'b0;
    hit_factor_y     = 1'b0;
    hit_product_high = 1'b0;
    hit_product_low  = 1'b0;
    hit_sum_byte1    = 1'b0;
    hit_sum_byte0    = 1'b0;
    hit_sum_byte3    = 1'b0;
    hit_sum_byte2    = 1'b0;
    if (in_bank)
    begin
      if (bus_address == mac_pkg::PRODUCT_FACTOR_X_ADDR)
        hit_factor_x = 1'b1;
      else if (bus_address == mac_pkg::PRODUCT_FACTOR_Y_ADDR)
        hit_factor_y = 1'b1;
      else if (bus_address == mac_pkg::PRODUCT_HIGH_BYTE_ADDR)
        hit_product_high = 1'b1;
      else if (bus_address == mac_pkg::PRODUCT_LOW_BYTE_ADDR)
        hit_product_low = 1'b1;
      else if (bus_address == mac_pkg::SUM_BYTE1_ADDR)
        hit_sum_byte1 = 1'b1;
      else if (bus_address == mac_pkg::SUM_BYTE0_ADDR)
        hit_sum_byte0 = 1'b1;
      else if (bus_address == mac_pkg::SUM_BYTE3_ADDR)
        hit_sum_byte3 = 1'b1;
      else if (bus_address == mac_pkg::SUM_BYTE2_ADDR)
        hit_sum_byte2 = 1'b1;
    end
  end

  // Writes to the two product registers match nothing here and are
  // dropped without side effects.
  always_comb
  begin
    write_product_factor_x = 1'b0;
    write_product_factor_y = 1'b0;
    write_acc_x = 1'b0;
    write_acc_y = 1'b0;
    write_clear = 1'b0;
    if (bus_write)
    begin
      if (hit_factor_x)
        write_product_factor_x = 1'b1;
      else if (hit_factor_y)
        write_product_factor_y = 1'b1;
      else if (hit_sum_byte1)
        write_acc_x = 1'b1;
      else if (hit_sum_byte0)
        write_acc_y = 1'b1;
      else if (hit_sum_byte3)
        write_clear = 1'b1;
      else if (hit_sum_byte2)
        write_clear = 1'b1;
    end
  end

  // Either X register feeds the one shared X factor, likewise for Y.
  assign any_x_write = write_product_factor_x | write_acc_x;
  assign any_y_write = write_product_factor_y | write_acc_y;

  // ------------------------------------------------------------------
  // Operand registers
  // ------------------------------------------------------------------
  // The multiplier sees the operand being written, not the stored one,
  // so the product is ready at the very edge that takes the write.
  always_comb
  begin
    next_x = factor_x;
    next_y = factor_y;
    if (any_x_write)
      next_x = bus_write_data;
    if (any_y_write)
      next_y = bus_write_data;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      factor_x <= mac_pkg::FACTOR_RESET;
    else
      factor_x <= next_x;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      factor_y <= mac_pkg::FACTOR_RESET;
    else
      factor_y <= next_y;
  end

  // ------------------------------------------------------------------
  // Multiplier
  // ------------------------------------------------------------------
  signed_multiplier multiplier (
    .factor_x (next_x),
    .factor_y (next_y),
    .product  (next_product)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      product <= mac_pkg::PRODUCT_RESET;
    else if (any_x_write || any_y_write)
      product <= next_product;
  end

  // ------------------------------------------------------------------
  // Accumulator control
  // ------------------------------------------------------------------
  // Only the accumulate registers start an add; a plain operand write
  // refreshes the product and leaves the sum alone.
  assign acc.add_strobe   = write_acc_x | write_acc_y;
  assign acc.addend       = $signed(next_product);
  assign acc.clear_strobe = write_clear;

  split_accumulator accumulator (
    .clock (clock),
    .reset (reset),
    .acc   (acc.accum)
  );

  // ------------------------------------------------------------------
  // Operation tracking
  // ------------------------------------------------------------------
  always_comb
  begin
    next_operation = operation;
    if (write_clear)
      next_operation = mac_pkg::op_clear;
    else if (acc.add_strobe)
      next_operation = mac_pkg::op_accumulate;
    else if (write_product_factor_x || write_product_factor_y)
      next_operation = mac_pkg::op_multiply;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      operation <= mac_pkg::op_none;
    else
      operation <= next_operation;
  end

  // ------------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------------
  // Each status port leaves its own flip-flop, at the cost of a few
  // bits that duplicate internal state.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      last_operation <= mac_pkg::op_none;
    else
      last_operation <= next_operation;
  end

  // High while the upper half still owes its pending add.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      sum_settling <= 1'b0;
    else
      sum_settling <= acc.add_strobe;
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Reads are answered from a register one cycle after the strobe. The
  // operand registers are write-only and read back as zero, as does
  // every address this unit does not own.
  always_comb
  begin
    next_read_data = mac_pkg::UNMAPPED_READ;
    if (hit_factor_x || hit_factor_y)
      next_read_data = mac_pkg::UNMAPPED_READ;
    else if (hit_product_high)
      next_read_data = product[15:8];
    else if (hit_product_low)
      next_read_data = product[7:0];
    else if (hit_sum_byte1)
      next_read_data = acc.sum[15:8];
    else if (hit_sum_byte0)
      next_read_data = acc.sum[7:0];
    else if (hit_sum_byte3)
      next_read_data = acc.sum[31:24];
    else if (hit_sum_byte2)
      next_read_data = acc.sum[23:16];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      bus_read_data <= mac_pkg::READ_RESET;
    else if (bus_read)
      bus_read_data <= next_read_data;
  end

endmodule : signed_multiply_accumulate

`default_nettype wire

// ===== mac_asserts.sv
// Checker for the multiply/accumulate register unit.
`timescale 1ns/10ps
`default_nettype none
module mac_asserts (
  input wire logic       clock,          // Unit clock
  input wire logic       reset,          // Async reset, active high
  input wire logic       bus_bank,       // Bank select
  input wire logic [7:0] bus_address,    // Register address
  input wire logic       bus_write,      // Write strobe
  input wire logic       bus_read,       // Read strobe
  input wire logic [7:0] bus_write_data, // Write data
  input wire logic [7:0] bus_read_data,  // Read answer
  input wire logic [1:0] last_operation, // Last operation kind
  input wire logic       sum_settling    // Upper sum pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Address pairs e8/e9, ea/eb, ec/ed and ee/ef differ only in bit 0.
  wire mul_w = bus_write && !bus_bank && bus_address[7:1] == 7'h74;
  wire mac_w = bus_write && !bus_bank && bus_address[7:1] == 7'h76;
  wire clr_w = bus_write && !bus_bank && bus_address[7:1] == 7'h77;
  wire rd = bus_read && !bus_bank;
  sequence clear_then_low;
    clr_w ##1 (rd && bus_address[7:1] == 7'h76);
  endsequence
  sequence clear_then_high;
    clr_w ##1 !bus_write ##1 (rd && bus_address[7:1] == 7'h77);
  endsequence
  sequence zero_then_product;
    (mul_w && bus_write_data == 8'h00) ##1 (rd && bus_address[7:1] == 7'h75);
  endsequence
  mul_op_a: assert property (mul_w |=> last_operation == 2'h1
    && !sum_settling) else $error("multiply write status wrong");
  mac_op_a: assert property (mac_w |=> last_operation == 2'h2
    && sum_settling) else $error("accumulate write status wrong");
  clear_op_a: assert property (clr_w |=> last_operation == 2'h3)
    else $error("clear write status wrong");
  settle_end_a: assert property (!mac_w |=> !sum_settling)
    else $error("upper sum settling too long");
  clear_low_a: assert property (clear_then_low |=> !bus_read_data)
    else $error("low sum byte not cleared");
  clear_high_a: assert property (clear_then_high |=> !bus_read_data)
    else $error("high sum byte not cleared");
  write_only_a: assert property (rd && bus_address[7:1] == 7'h74
    |=> bus_read_data == 8'h00) else $error("factor register readable");
  zero_prod_a: assert property (zero_then_product |=> !bus_read_data)
    else $error("product of zero factor not zero");
endmodule : mac_asserts
bind signed_multiply_accumulate mac_asserts u_asserts (.clock(clock),
  .reset(reset), .bus_bank(bus_bank), .bus_address(bus_address),
  .bus_write(bus_write), .bus_read(bus_read),
  .bus_write_data(bus_write_data), .bus_read_data(bus_read_data),
  .last_operation(last_operation), .sum_settling(sum_settling));
`default_nettype wire

// ===== cpu_bus_model.sv
// Model of the CPU that drives the unit's register bus.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
  input  wire logic       clock,          // Unit clock
  output logic            bus_bank,       // Bank select
  output logic      [7:0] bus_address,    // Register address
  output logic            bus_write,      // Write strobe
  output logic            bus_read,       // Read strobe
  output logic      [7:0] bus_write_data  // Write data
);
  logic mac_recent;
  initial
  begin
    bus_bank = 1'b0;
    bus_address = 8'h00;
    bus_write = 1'b0;
    bus_read = 1'b0;
    bus_write_data = 8'h00;
    mac_recent = 1'b0;
  end
  // Idle cycles invert the released lines so stale values never match.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      bus_write <= 1'b0;
      bus_read <= 1'b0;
      bus_address <= ~bus_address;
      bus_write_data <= ~bus_write_data;
      mac_recent = 1'b0;
    end
  endtask : idle
  task automatic write(input logic b, input logic [7:0] a, d);
    @(posedge clock);
    bus_bank <= b;
    bus_address <= a;
    bus_write_data <= d;
    bus_read <= 1'b0;
    bus_write <= 1'b1;
    mac_recent = !b && a[7:1] == 7'h76;
  endtask : write
  task automatic read(input logic b, input logic [7:0] a);
    if (!b && a[7:1] == 7'h77 && mac_recent)
      idle(1);
    @(posedge clock);
    bus_bank <= b;
    bus_address <= a;
    bus_write_data <= ~bus_write_data;
    bus_write <= 1'b0;
    bus_read <= 1'b1;
    mac_recent = 1'b0;
  endtask : read
endmodule : cpu_bus_model
`default_nettype wire

// ===== signed_multiply_accumulate_tb.sv
// Self-checking testbench for the multiply/accumulate register unit.
`timescale 1ns/10ps
`default_nettype none
module signed_multiply_accumulate_tb;
  logic clock, reset, bus_bank, bus_write, bus_read, sum_settling;
  logic [7:0] bus_address, bus_write_data, bus_read_data, mx, my, got;
  logic [1:0] last_operation;
  logic [31:0] msum;
  logic [15:0] p;
  logic [7:0] q[$];
  logic rd_seen = 1'b0;
  int errors, compares;
  integer seed = 32'h5854ef42;
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  cpu_bus_model u_cpu (.clock(clock), .bus_bank(bus_bank),
    .bus_address(bus_address), .bus_write(bus_write),
    .bus_read(bus_read), .bus_write_data(bus_write_data));
  signed_multiply_accumulate u_dut (.clock(clock), .reset(reset),
    .bus_bank(bus_bank), .bus_address(bus_address),
    .bus_write(bus_write), .bus_read(bus_read),
    .bus_write_data(bus_write_data), .bus_read_data(bus_read_data),
    .last_operation(last_operation), .sum_settling(sum_settling));
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Read answers arrive one cycle after the edge that took the strobe.
  always @(posedge clock)
  begin
    if (rd_seen)
    begin
      got = q.pop_front();
      compares++;
      if (bus_read_data !== got)
      begin
        errors++;
        $display("[ERR] %0t got %h exp %h", $time, bus_read_data, got);
      end
    end
    rd_seen <= bus_read;
  end
  task automatic wr(input logic b, input logic [7:0] a, d);
    if (!b && (a == 8'he8 || a == 8'hec))
      mx = d;
    if (!b && (a == 8'he9 || a == 8'hed))
      my = d;
    p = $signed(mx) * $signed(my);
    if (!b && a[7:1] == 7'h76)
      msum = msum + {{16{p[15]}}, p};
    if (!b && a[7:1] == 7'h77)
      msum = 32'h00000000;
    u_cpu.write(b, a, d);
  endtask : wr
  function automatic logic [7:0] expect_of(input logic b, input logic [7:0] a);
    if (b)
      return 8'h00;
    case (a)
      8'hea: return p[15:8];
      8'heb: return p[7:0];
      8'hec: return msum[15:8];
      8'hed: return msum[7:0];
      8'hee: return msum[31:24];
      8'hef: return msum[23:16];
      default: return 8'h00;
    endcase
  endfunction : expect_of
  task automatic rd(input logic b, input logic [7:0] a);
    q.push_back(expect_of(b, a));
    u_cpu.read(b, a);
  endtask : rd
  task automatic rd_all();
    for (int i = 8'he8; i < 8'hf0; i++)
      rd(1'b0, 8'(i));
  endtask : rd_all
  initial
  begin
    reset = 1'b1;
    {mx, my, p, msum, errors, compares} = '0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd_all();
    rd(1'b1, 8'hed);
    rd(1'b0, 8'he0);
    repeat (60)
    begin
      wr(1'b0, 8'he8 + 8'($random(seed) & 7), 8'($random(seed)));
      rd_all();
    end
    // A reset in mid-run must bring every register back to zero.
    u_cpu.idle(3);
    reset <= 1'b1;
    {mx, my, p, msum} = '0;
    u_cpu.idle(2);
    reset <= 1'b0;
    rd_all();
    // Back-to-back accumulates of negative products.
    wr(1'b0, 8'hee, 8'h00);
    wr(1'b0, 8'he9, 8'h7f);
    wr(1'b0, 8'hec, 8'h80);
    wr(1'b0, 8'hed, 8'h7f);
    rd_all();
    wr(1'b0, 8'he8, 8'h00);
    rd(1'b0, 8'hea);
    rd(1'b0, 8'hed);
    wr(1'b1, 8'hee, 8'h00);
    wr(1'b0, 8'hed, 8'h05);
    wr(1'b0, 8'hef, 8'h3c);
    rd(1'b0, 8'hec);
    rd(1'b0, 8'hee);
    u_cpu.idle(3);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
endmodule : signed_multiply_accumulate_tb
`default_nettype wire
